/* cbr_core_model.sv */
`timescale 1ns/1ps
// ****
// Core side: drives register writes, ALU flag updates and interrupt events.
// ****
module cbr_core_model
  import cbr_pkg::*;
(
  // Clock.
  input  wire logic        i_mclk,
  // Core port drive.
  output logic             o_ce,
  output logic             o_wr_en,
  output logic [3:0]       o_wr_sel,
  output logic [15:0]      o_wr_data,
  output logic             o_alu_flags_en,
  output logic [16:0]      o_alu_result,
  output logic [1:0]       o_alu_width,
  output logic             o_alu_carry,
  output logic             o_alu_ovf,
  output logic             o_irq_req,
  output logic [2:0]       o_irq_prio,
  output logic             o_irq_maskable,
  output logic             o_irq_accept,
  output logic             o_irq_hw,
  output logic             o_trap_exec,
  output logic [5:0]       o_trap_num
);
  // Clock enable starts high; only frozen_wr drops it, for one cycle, to model a stall.
  initial begin
    o_ce = 1'b1;
    {o_wr_en, o_wr_sel, o_wr_data, o_alu_flags_en, o_alu_result, o_alu_width} = '0;
    {o_alu_carry, o_alu_ovf, o_irq_req, o_irq_prio, o_irq_maskable} = '0;
    {o_irq_accept, o_irq_hw, o_trap_exec, o_trap_num} = '0;
  end
  // A write offered while the core stalls must be lost.
  task frozen_wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge i_mclk);
    {o_ce, o_wr_en, o_wr_sel, o_wr_data} <= {1'b0, 1'b1, s, d};
    @(posedge i_mclk);
    {o_ce, o_wr_en} <= 2'b10;
  endtask : frozen_wr
  task wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge i_mclk);
    {o_wr_en, o_wr_sel, o_wr_data} <= {1'b1, s, d};
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
  endtask : wr
  task alu(input logic [16:0] r, input logic [1:0] w, input logic c, input logic v);
    @(posedge i_mclk);
    {o_alu_flags_en, o_alu_result, o_alu_width, o_alu_carry, o_alu_ovf} <= {1'b1, r, w, c, v};
    @(posedge i_mclk);
    o_alu_flags_en <= 1'b0;
  endtask : alu
  task req(input logic [2:0] p, input logic m);
    @(posedge i_mclk);
    {o_irq_req, o_irq_prio, o_irq_maskable} <= {1'b1, p, m};
  endtask : req
  task accept(input logic hw);
    @(posedge i_mclk);
    {o_irq_accept, o_irq_hw} <= {1'b1, hw};
    @(posedge i_mclk);
    o_irq_accept <= 1'b0;
  endtask : accept
  task trap(input logic [5:0] n);
    @(posedge i_mclk);
    {o_trap_exec, o_trap_num} <= {1'b1, n};
    @(posedge i_mclk);
    o_trap_exec <= 1'b0;
  endtask : trap
endmodule : cbr_core_model

/* cbr_pkg.sv */
// Behaviour
// - Seven registers duplicated into two banks.
// - Four 16-bit data registers; byte halves (the code gives byte views of data zero and data one only).
// - Data zero/two, one/three pair to 32 bits.
// - Two 16-bit address registers pair 32-bit.
// - Frame base register is 16 bits.
// - Vector table base is 20 bits.
// - Next-instruction pointer is 20 bits.
// - Stack select picks irq or user pointer.
// - Hardware interrupt or low trap clears stack select.
// - Static base register is 16 bits.
// - Eleven-bit flag word holds CPU state.
// - Carry captures ALU carry, borrow, shift-out.
// - Zero flag set on zero result.
// - Sign flag set on negative result.
// - Bank select flag chooses visible bank.
// - Overflow flag set on arithmetic overflow.
// - Interrupt enable gates maskable interrupts.
// - Accepting interrupt clears interrupt enable.
// - Request needs priority above current level; non-maskable requests pass at any level.
// - Reserved flag bits written zero, read zero.
package cbr_pkg;
  // ****************************************
  // Register selectors, also APB word indices.
  // ****************************************
  localparam logic [3:0] SEL_DATA0  = 4'h0;
  localparam logic [3:0] SEL_DATA1  = 4'h1;
  localparam logic [3:0] SEL_DATA2  = 4'h2;
  localparam logic [3:0] SEL_DATA3  = 4'h3;
  localparam logic [3:0] SEL_ADDR0  = 4'h4;
  localparam logic [3:0] SEL_ADDR1  = 4'h5;
  localparam logic [3:0] SEL_FRAME  = 4'h6;
  localparam logic [3:0] SEL_VECTB  = 4'h7;
  localparam logic [3:0] SEL_NIP    = 4'h8;
  localparam logic [3:0] SEL_USP    = 4'h9;
  localparam logic [3:0] SEL_ISP    = 4'ha;
  localparam logic [3:0] SEL_STATB  = 4'hb;
  localparam logic [3:0] SEL_FLAGS  = 4'hc;
  localparam logic [3:0] SEL_SP     = 4'hd;
  localparam logic [3:0] SEL_BYTE0L = 4'he;
  localparam logic [3:0] SEL_BYTE0H = 4'hf;
  // Wide pair and data-one byte views are reached on the core port only.
  localparam logic [2:0] WID_DATA_LOW  = 3'h1;
  localparam logic [2:0] WID_DATA_HIGH = 3'h2;
  localparam logic [2:0] WID_ADDR      = 3'h3;
  localparam logic [2:0] WID_BYTE1L    = 3'h4;
  localparam logic [2:0] WID_BYTE1H    = 3'h5;
  // ****************************************
  // Flag word layout.
  // ****************************************
  localparam int FLG_C   = 0;
  localparam int FLG_D   = 1;
  localparam int FLG_Z   = 2;
  localparam int FLG_S   = 3;
  localparam int FLG_B   = 4;
  localparam int FLG_O   = 5;
  localparam int FLG_I   = 6;
  localparam int FLG_U   = 7;
  localparam int FLG_IPL = 12;
  localparam int FLG_W   = 15;
  localparam logic [14:0] FLG_MASK  = 15'h70ff;
  localparam logic [14:0] FLG_RESET = 15'h0000;
  localparam logic [4:0]  TRAP_LOW_MAX = 5'h1f;
  localparam int APB_IDX_LO = 2;
endpackage : cbr_pkg

/* cbr_regs.sv */
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module cbr_regs
  import cbr_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Core register write port.
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_wr_sel,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_wide_wr_en,
  input  wire logic [2:0]  i_wide_sel,
  input  wire logic [31:0] i_wide_wr_data,
  output logic      [31:0] o_wide_rd_data,
  // Instruction pointer update.
  input  wire logic        i_nip_load,
  input  wire logic [19:0] i_nip_value,
  // ALU flag update.
  input  wire logic        i_alu_flags_en,
  input  wire logic [16:0] i_alu_result,
  input  wire logic [1:0]  i_alu_width,
  input  wire logic        i_alu_carry,
  input  wire logic        i_alu_ovf,
  // Interrupt acceptance.
  input  wire logic        i_irq_req,
  input  wire logic [2:0]  i_irq_prio,
  input  wire logic        i_irq_maskable,
  input  wire logic        i_irq_accept,
  input  wire logic        i_irq_hw,
  input  wire logic        i_trap_exec,
  input  wire logic [5:0]  i_trap_num,
  output logic             o_irq_enabled,
  // Register views.
  output logic      [15:0] o_stack_ptr,
  output logic      [15:0] o_frame_base_reg,
  output logic      [15:0] o_static_base_reg,
  output logic      [19:0] o_vector_table_base,
  output logic      [19:0] o_next_instr_pointer,
  output logic      [10:0] o_cpu_flag_word,
  output logic      [2:0]  o_cpu_priority_level,
  output logic             o_bank_sel
);
  // ****************************************
  // State.
  // ****************************************
  logic [15:0] bank_ff     [2][7];
  logic [15:0] nxt_bank    [2][7];
  logic [19:0] vectb_ff,  nxt_vectb;
  logic [19:0] nip_ff,    nxt_nip;
  logic [15:0] usp_ff,    nxt_usp;
  logic [15:0] isp_ff,    nxt_isp;
  logic [15:0] statb_ff,  nxt_statb;
  logic [14:0] flg_ff,    nxt_flg;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        bsel;
  logic        apb_acc;
  logic        apb_wr;
  logic [3:0]  apb_idx;
  logic        apb_hit;
  logic [15:0] apb_wdata;
  logic [15:0] zero_test;
  logic        neg_bit;

  assign bsel    = flg_ff[FLG_B];
  assign apb_acc = i_psel && i_penable;
  assign apb_idx = i_paddr[APB_IDX_LO +: 4];
  assign apb_hit = (i_paddr[31:APB_IDX_LO+4] == '0) && (i_paddr[1:0] == 2'h0);
  assign apb_wr  = apb_acc && i_pwrite && apb_hit && (i_pstrb != 4'h0);

  // Byte lanes beyond bit 15 are dropped, except that the 20-bit vector table base and next-instruction pointer take bits 19:0.
  always_comb begin
    apb_wdata = i_pwdata[15:0];
  end

  // Narrow results are tested on their own width only.
  always_comb begin
    zero_test = i_alu_result[15:0];
    neg_bit   = i_alu_result[15];
    if (i_alu_width == 2'h0) begin
      zero_test = {8'h00, i_alu_result[7:0]};
      neg_bit   = i_alu_result[7];
    end
  end

  always_comb begin
    nxt_bank  = bank_ff;
    nxt_vectb = vectb_ff;
    nxt_nip   = nip_ff;
    nxt_usp   = usp_ff;
    nxt_isp   = isp_ff;
    nxt_statb = statb_ff;
    nxt_flg   = flg_ff;
    // APB access goes first, the core port overrides in the same cycle.
    if (apb_wr) begin
      case (apb_idx)
        SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3, SEL_ADDR0, SEL_ADDR1, SEL_FRAME: begin
          nxt_bank[bsel][apb_idx[2:0]] = apb_wdata;
        end
        SEL_VECTB: nxt_vectb = i_pwdata[19:0];
        SEL_NIP:   nxt_nip   = i_pwdata[19:0];
        SEL_USP:   nxt_usp   = apb_wdata;
        SEL_ISP:   nxt_isp   = apb_wdata;
        SEL_STATB: nxt_statb = apb_wdata;
        SEL_FLAGS: nxt_flg   = apb_wdata[14:0] & FLG_MASK;
        default: begin
        end
      endcase
    end
    if (i_wr_en) begin
      case (i_wr_sel)
        SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3: begin
          nxt_bank[bsel][i_wr_sel[2:0]] = i_wr_data;
        end
        SEL_ADDR0, SEL_ADDR1: nxt_bank[bsel][i_wr_sel[2:0]] = i_wr_data;
        SEL_FRAME: nxt_bank[bsel][6] = i_wr_data;
        SEL_VECTB: nxt_vectb = {4'h0, i_wr_data};
        SEL_USP:   nxt_usp   = i_wr_data;
        SEL_ISP:   nxt_isp   = i_wr_data;
        SEL_STATB: nxt_statb = i_wr_data;
        SEL_FLAGS: nxt_flg   = i_wr_data[14:0] & FLG_MASK;
        SEL_SP: begin
          if (flg_ff[FLG_U]) begin
            nxt_usp = i_wr_data;
          end else begin
            nxt_isp = i_wr_data;
          end
        end
        SEL_BYTE0L: nxt_bank[bsel][0][7:0]  = i_wr_data[7:0];
        SEL_BYTE0H: nxt_bank[bsel][0][15:8] = i_wr_data[7:0];
        default: begin
        end
      endcase
    end
    if (i_wide_wr_en) begin
      case (i_wide_sel)
        WID_DATA_LOW: begin
          nxt_bank[bsel][0] = i_wide_wr_data[15:0];
          nxt_bank[bsel][2] = i_wide_wr_data[31:16];
        end
        WID_DATA_HIGH: begin
          nxt_bank[bsel][1] = i_wide_wr_data[15:0];
          nxt_bank[bsel][3] = i_wide_wr_data[31:16];
        end
        WID_ADDR: begin
          nxt_bank[bsel][4] = i_wide_wr_data[15:0];
          nxt_bank[bsel][5] = i_wide_wr_data[31:16];
        end
        WID_BYTE1L: nxt_bank[bsel][1][7:0]  = i_wide_wr_data[7:0];
        WID_BYTE1H: nxt_bank[bsel][1][15:8] = i_wide_wr_data[7:0];
        default: begin
        end
      endcase
    end
    if (i_nip_load) begin
      nxt_nip = i_nip_value;
    end
    if (i_alu_flags_en) begin
      nxt_flg[FLG_C] = i_alu_carry;
      nxt_flg[FLG_Z] = (zero_test == 16'h0000);
      nxt_flg[FLG_S] = neg_bit;
      nxt_flg[FLG_O] = i_alu_ovf;
    end
    // Acceptance comes after the APB, core and ALU flag writes, so it wins over any software write to the flags.
    if (i_irq_accept) begin
      nxt_flg[FLG_I] = 1'b0;
      if (i_irq_hw) begin
        nxt_flg[FLG_U] = 1'b0;
      end
    end
    if (i_trap_exec && (i_trap_num <= {1'b0, TRAP_LOW_MAX})) begin
      nxt_flg[FLG_U] = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int b = 0; b < 2; b++) begin
        for (int r = 0; r < 7; r++) begin
          bank_ff[b][r] <= 16'h0000;
        end
      end
      vectb_ff <= 20'h00000;
      nip_ff   <= 20'h00000;
      usp_ff   <= 16'h0000;
      isp_ff   <= 16'h0000;
      statb_ff <= 16'h0000;
      flg_ff   <= FLG_RESET;
    end else if (i_ce) begin
      bank_ff  <= nxt_bank;
      vectb_ff <= nxt_vectb;
      nip_ff   <= nxt_nip;
      usp_ff   <= nxt_usp;
      isp_ff   <= nxt_isp;
      statb_ff <= nxt_statb;
      flg_ff   <= nxt_flg;
    end
  end

  // ****************************************
  // APB read path.
  // ****************************************
  always_comb begin
    nxt_prdata = prdata_ff;
    if (i_psel && !i_penable && !i_pwrite) begin
      nxt_prdata = 32'h00000000;
      case (i_paddr[APB_IDX_LO +: 4])
        SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3, SEL_ADDR0, SEL_ADDR1, SEL_FRAME: begin
          nxt_prdata[15:0] = bank_ff[bsel][i_paddr[APB_IDX_LO +: 3]];
        end
        SEL_VECTB:  nxt_prdata[19:0] = vectb_ff;
        SEL_NIP:    nxt_prdata[19:0] = nip_ff;
        SEL_USP:    nxt_prdata[15:0] = usp_ff;
        SEL_ISP:    nxt_prdata[15:0] = isp_ff;
        SEL_STATB:  nxt_prdata[15:0] = statb_ff;
        SEL_FLAGS:  nxt_prdata[14:0] = flg_ff & FLG_MASK;
        SEL_SP:     nxt_prdata[15:0] = flg_ff[FLG_U] ? usp_ff : isp_ff;
        SEL_BYTE0L: nxt_prdata[7:0]  = bank_ff[bsel][0][7:0];
        SEL_BYTE0H: nxt_prdata[7:0]  = bank_ff[bsel][0][15:8];
        default: begin
        end
      endcase
      // Refused addresses must not leak a register through the aliased index.
      if (!apb_hit) begin
        nxt_prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_ff <= 32'h00000000;
    end else if (i_ce) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Read data is fetched in the setup cycle, so the slave never waits.
  assign o_prdata  = prdata_ff;
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && !apb_hit;

  // ****************************************
  // Core-side views.
  // ****************************************
  always_comb begin
    o_wide_rd_data = 32'h00000000;
    case (i_wide_sel)
      WID_DATA_LOW:  o_wide_rd_data = {bank_ff[bsel][2], bank_ff[bsel][0]};
      WID_DATA_HIGH: o_wide_rd_data = {bank_ff[bsel][3], bank_ff[bsel][1]};
      WID_ADDR:      o_wide_rd_data = {bank_ff[bsel][5], bank_ff[bsel][4]};
      WID_BYTE1L:    o_wide_rd_data[7:0] = bank_ff[bsel][1][7:0];
      WID_BYTE1H:    o_wide_rd_data[7:0] = bank_ff[bsel][1][15:8];
      default:       o_wide_rd_data = {16'h0000, bank_ff[bsel][0]};
    endcase
  end

  // Non-maskable requests ignore both the enable flag and the level.
  assign o_irq_enabled = i_irq_req && (!i_irq_maskable ||
                         (flg_ff[FLG_I] && (i_irq_prio > flg_ff[FLG_IPL +: 3])));

  assign o_stack_ptr          = flg_ff[FLG_U] ? usp_ff : isp_ff;
  assign o_frame_base_reg     = bank_ff[bsel][6];
  assign o_static_base_reg    = statb_ff;
  assign o_vector_table_base  = vectb_ff;
  assign o_next_instr_pointer = nip_ff;
  assign o_cpu_flag_word      = {flg_ff[14:12], flg_ff[7:0]};
  assign o_cpu_priority_level = flg_ff[FLG_IPL +: 3];
  assign o_bank_sel           = bsel;
endmodule : cbr_regs

/* cbr_regs_monitor.sv */
`timescale 1ns/1ps
// ****
// Flag and interrupt checks.
// ****
module cbr_regs_monitor
  import cbr_pkg::*;
(
  // Clock and core inputs.
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic        i_ce,
  input wire logic        i_alu_flags_en,
  input wire logic [16:0] i_alu_result,
  input wire logic [1:0]  i_alu_width,
  input wire logic        i_alu_carry,
  input wire logic        i_alu_ovf,
  input wire logic        i_irq_req,
  input wire logic [2:0]  i_irq_prio,
  input wire logic        i_irq_maskable,
  input wire logic        i_irq_accept,
  input wire logic        i_irq_hw,
  input wire logic        i_trap_exec,
  input wire logic [5:0]  i_trap_num,
  // Observed outputs.
  input wire logic        o_irq_enabled,
  input wire logic [10:0] o_cpu_flag_word,
  input wire logic [2:0]  o_cpu_priority_level
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic alu_go;
  logic res_zero;
  logic res_neg;
  // Byte operations judge only the low eight bits.
  assign alu_go   = i_ce && i_alu_flags_en;
  assign res_zero = (i_alu_width == 2'h0) ? (i_alu_result[7:0] == 8'h00) : (i_alu_result[15:0] == 16'h0000);
  assign res_neg  = (i_alu_width == 2'h0) ? i_alu_result[7] : i_alu_result[15];
  a_carry_kept : assert property (
    alu_go |=> o_cpu_flag_word[FLG_C] == $past(i_alu_carry)) else $error("carry flag wrong");
  a_zero_flag : assert property (
    alu_go |=> o_cpu_flag_word[FLG_Z] == $past(res_zero)) else $error("zero flag wrong");
  a_sign_flag : assert property (
    alu_go |=> o_cpu_flag_word[FLG_S] == $past(res_neg)) else $error("sign flag wrong");
  a_ovf_flag : assert property (
    alu_go |=> o_cpu_flag_word[FLG_O] == $past(i_alu_ovf)) else $error("overflow flag wrong");
  a_accept_clears_ien : assert property (
    i_ce && i_irq_accept |=> !o_cpu_flag_word[FLG_I]) else $error("enable not cleared");
  a_stack_sel_clear : assert property (
    i_ce && (i_irq_accept && i_irq_hw || i_trap_exec && i_trap_num <= 6'h1f) |=> !o_cpu_flag_word[FLG_U])
    else $error("stack select not cleared");
  a_irq_gate_prio : assert property (
    o_irq_enabled == (i_irq_req && (!i_irq_maskable
      || o_cpu_flag_word[FLG_I] && i_irq_prio > o_cpu_priority_level))) else $error("request gate wrong");
  a_level_field : assert property (
    o_cpu_priority_level == o_cpu_flag_word[10:8]) else $error("level field wrong");
  a_reset_flags : assert property (
    $rose(i_arst_n) |-> o_cpu_flag_word == 11'h000) else $error("flags not cleared by reset");
  a_freeze_flags : assert property (
    !i_ce |=> $stable(o_cpu_flag_word)) else $error("flags moved while frozen");
endmodule : cbr_regs_monitor
bind cbr_regs cbr_regs_monitor u_mon (.*);

/* cpu_banked_register_set_test.sv */
`timescale 1ns/1ps
module cpu_banked_register_set_test
  import cbr_pkg::*;
;
  logic        i_mclk = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [31:0] i_paddr = '0, i_pwdata = '0, i_wide_wr_data = '0, o_prdata, o_wide_rd_data, rd;
  logic [3:0]  i_pstrb = 4'hf, i_wr_sel;
  logic        i_wide_wr_en = 1'b0, i_nip_load = 1'b0, o_pready, o_pslverr, o_irq_enabled, o_bank_sel, se;
  logic        i_ce, i_wr_en, i_alu_flags_en, i_alu_carry, i_alu_ovf, i_irq_req, i_irq_maskable;
  logic        i_irq_accept, i_irq_hw, i_trap_exec;
  logic [19:0] i_nip_value = '0, o_vector_table_base, o_next_instr_pointer;
  logic [2:0]  i_wide_sel = 3'h0, i_irq_prio, o_cpu_priority_level;
  logic [15:0] i_wr_data, o_stack_ptr, o_frame_base_reg, o_static_base_reg;
  logic [16:0] i_alu_result;
  logic [1:0]  i_alu_width;
  logic [5:0]  i_trap_num;
  logic [10:0] o_cpu_flag_word;
  int          n_mismatch = 0, total_checks = 0;
  always #50 i_mclk = ~i_mclk;
  cbr_regs dut (.*);
  cbr_core_model u_core (.i_mclk(i_mclk), .o_ce(i_ce), .o_wr_en(i_wr_en), .o_wr_sel(i_wr_sel),
    .o_wr_data(i_wr_data), .o_alu_flags_en(i_alu_flags_en), .o_alu_result(i_alu_result),
    .o_alu_width(i_alu_width), .o_alu_carry(i_alu_carry), .o_alu_ovf(i_alu_ovf), .o_irq_req(i_irq_req),
    .o_irq_prio(i_irq_prio), .o_irq_maskable(i_irq_maskable), .o_irq_accept(i_irq_accept),
    .o_irq_hw(i_irq_hw), .o_trap_exec(i_trap_exec), .o_trap_num(i_trap_num));
  // ****
  // Bus and compare helpers.
  // ****
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(posedge i_mclk);
    while (o_pready !== 1'b1) @(posedge i_mclk);
    rd = o_prdata;
    se = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask : apb
  task rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task wide(input logic [2:0] s, input logic [31:0] e);
    @(posedge i_mclk);
    i_wide_sel <= s;
    @(negedge i_mclk);
    chk("wide", e, o_wide_rd_data);
  endtask : wide
  task wwide(input logic [2:0] s, input logic [31:0] d);
    @(posedge i_mclk);
    {i_wide_wr_en, i_wide_sel, i_wide_wr_data} <= {1'b1, s, d};
    @(posedge i_mclk);
    i_wide_wr_en <= 1'b0;
  endtask : wwide
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ****
  // Scenarios.
  // ****
  task t_reset;
    rdchk("flags", 32'h30, 32'h0);
    chk("flag_out", 32'h0, o_cpu_flag_word);
    rdchk("unmapped", 32'h40, 32'h0);
    chk("slverr", 32'h1, se);
    $display("reset test done");
  endtask : t_reset
  task t_banks;
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, 32'h30, {27'h0, b[0], 4'h0});
      for (int i = 0; i < 7; i++) apb(1'b1, i * 4, 32'h1230 + b * 32'h4440 + i);
    end
    for (int i = 0; i < 7; i++) rdchk("bank1", i * 4, 32'h5670 + i);
    chk("bank_sel", 32'h1, o_bank_sel);
    apb(1'b1, 32'h30, 32'h0);
    for (int i = 0; i < 7; i++) rdchk("bank0", i * 4, 32'h1230 + i);
    rdchk("byte_lo", 32'h38, 32'h30);
    rdchk("byte_hi", 32'h3c, 32'h12);
    u_core.wr(SEL_BYTE0H, 16'h00ab);
    rdchk("byte_wr", 32'h0, 32'hab30);
    rdchk("unmapped_rd", 32'h40, 32'h0);
    chk("unmapped_err", 32'h1, se);
    apb(1'b1, 32'h41, 32'hffff);
    rdchk("refused_wr", 32'h0, 32'hab30);
    wide(WID_DATA_LOW, 32'h1232ab30);
    wide(WID_DATA_HIGH, 32'h12331231);
    wide(WID_ADDR, 32'h12351234);
    wwide(WID_DATA_LOW, 32'h22221111);
    wide(WID_DATA_LOW, 32'h22221111);
    rdchk("pair_hi", 32'h8, 32'h2222);
    wwide(WID_BYTE1H, 32'h000000cd);
    wide(WID_BYTE1H, 32'h000000cd);
    wide(WID_BYTE1L, 32'h00000031);
    wwide(WID_ADDR, 32'h44443333);
    rdchk("addr_hi", 32'h14, 32'h4444);
    $display("bank test done");
  endtask : t_banks
  task t_widths;
    int          idx [4] = '{6, 7, 8, 11};
    logic [31:0] ex  [4] = '{32'hffff, 32'hfffff, 32'hfffff, 32'hffff};
    for (int k = 0; k < 4; k++) apb(1'b1, idx[k] * 4, 32'hffffffff);
    for (int k = 0; k < 4; k++) rdchk("width", idx[k] * 4, ex[k]);
    chk("nip_out", 32'hfffff, o_next_instr_pointer);
    chk("frame_out", 32'hffff, o_frame_base_reg);
    chk("vectb_out", 32'hfffff, o_vector_table_base);
    @(posedge i_mclk);
    {i_nip_load, i_nip_value} <= {1'b1, 20'h2468a};
    @(posedge i_mclk);
    i_nip_load <= 1'b0;
    @(negedge i_mclk);
    chk("nip_load", 32'h2468a, o_next_instr_pointer);
    u_core.frozen_wr(SEL_STATB, 16'h1234);
    @(negedge i_mclk);
    chk("frozen", 32'hffff, o_static_base_reg);
    $display("width test done");
  endtask : t_widths
  task t_alu;
    logic [16:0] r  [5] = '{17'h00000, 17'h08000, 17'h00100, 17'h00080, 17'h10080};
    logic [1:0]  w  [5] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
    logic [4:0]  cv [5] = '{5'h2, 5'h1, 5'h0, 5'h2, 5'h1};
    logic [7:0]  ex [5] = '{8'h05, 8'h28, 8'h04, 8'h09, 8'h20};
    for (int k = 0; k < 5; k++) begin
      u_core.alu(r[k], w[k], cv[k][1], cv[k][0]);
      @(negedge i_mclk);
      chk("alu_flags", ex[k], o_cpu_flag_word[7:0] & 8'h2d);
    end
    $display("alu test done");
  endtask : t_alu
  task t_irq;
    apb(1'b1, 32'h30, 32'h30c0);
    rdchk("flags", 32'h30, 32'h30c0);
    chk("flag_out", 32'h3c0, o_cpu_flag_word);
    chk("level", 32'h3, o_cpu_priority_level);
    for (int p = 0; p < 8; p++) begin
      u_core.req(p[2:0], 1'b1);
      @(negedge i_mclk);
      chk("gate", p > 3, o_irq_enabled);
    end
    apb(1'b1, 32'h30, 32'h3080);
    @(negedge i_mclk);
    chk("masked", 32'h0, o_irq_enabled);
    u_core.req(3'h7, 1'b0);
    @(negedge i_mclk);
    chk("nonmask", 32'h1, o_irq_enabled);
    apb(1'b1, 32'h24, 32'h1111);
    apb(1'b1, 32'h28, 32'h2222);
    chk("usp", 32'h1111, o_stack_ptr);
    u_core.trap(6'h20);
    @(negedge i_mclk);
    chk("trap32", 32'h1111, o_stack_ptr);
    u_core.trap(6'h1f);
    @(negedge i_mclk);
    chk("trap31", 32'h2222, o_stack_ptr);
    apb(1'b1, 32'h30, 32'h00c0);
    u_core.accept(1'b0);
    @(negedge i_mclk);
    chk("sw_accept_sp", 32'h1111, o_stack_ptr);
    chk("sw_accept_ien", 32'h0, o_cpu_flag_word[FLG_I]);
    u_core.accept(1'b1);
    @(negedge i_mclk);
    chk("hw_accept", 32'h2222, o_stack_ptr);
    $display("interrupt test done");
  endtask : t_irq
  initial begin
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    t_reset;
    t_banks;
    t_widths;
    t_alu;
    t_irq;
    report_and_stop;
  end
  // The tests need a few hundred cycles, so this span only cuts a hang.
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop;
  end
endmodule : cpu_banked_register_set_test
